// ---- pkg/bfm_pkg.sv ----
package bfm_pkg;

	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		BFM_OP_BSW_WORD   = 5'h00,
		BFM_OP_BSW_HALVES = 5'h01,
		BFM_OP_BSW_LOW_SX = 5'h02,
		BFM_OP_ROT_CARRY  = 5'h03,
		BFM_OP_SFX        = 5'h04,
		BFM_OP_UFX        = 5'h05,
		BFM_OP_SWH        = 5'h06,
		BFM_OP_ZWH        = 5'h07,
		BFM_OP_SMUL_ACC   = 5'h08,
		BFM_OP_SMUL_LONG  = 5'h09,
		BFM_OP_UMUL_ADD2  = 5'h0A,
		BFM_OP_POP        = 5'h0B,
		BFM_OP_PUSH       = 5'h0C,
		BFM_OP_STORE_ASC  = 5'h0D,
		BFM_OP_STORE_DESC = 5'h0E,
		BFM_OP_STORE_PAIR = 5'h0F,
		BFM_OP_EXCL_BYTE  = 5'h10,
		BFM_OP_EXCL_HALF  = 5'h11
	} bfm_op_t;

	typedef enum logic [1:0] {
		BFM_MUL_PLAIN = 2'h0,
		BFM_MUL_SACC  = 2'h1,
		BFM_MUL_UADD2 = 2'h2
	} bfm_mul_mode_t;

	typedef enum logic [1:0] {
		BFM_SIZE_BYTE = 2'h0,
		BFM_SIZE_HALF = 2'h1,
		BFM_SIZE_WORD = 2'h2
	} bfm_size_t;

	// ----------------------------------------------------------------
	// Fields, steps and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_N      = 3;
	localparam int unsigned FLAG_Z      = 2;
	localparam int unsigned FLAG_C      = 1;
	localparam int unsigned MUL_CYCLES  = 4;
	localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam logic [31:0] EXCL_DONE   = 32'h0000_0000;
	localparam logic [31:0] EXCL_FAILED = 32'h0000_0001;
	localparam logic [15:0] PAIR_MASK   = 16'h0003;
	localparam logic [15:0] EXCL_MASK   = 16'h0001;

endpackage

// ---- rtl/bfm_mul.sv ----
`timescale 1ns/1ps
module bfm_mul #(
	parameter int unsigned CYCLES = bfm_pkg::MUL_CYCLES
) (
	// Clock and reset
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rstn,
	// Request
	input  wire logic                  i_start,
	input  wire bfm_pkg::bfm_mul_mode_t i_mode,
	input  wire logic [31:0]           i_a,
	input  wire logic [31:0]           i_b,
	input  wire logic [31:0]           i_lo,
	input  wire logic [31:0]           i_hi,
	// Answer
	output logic                       o_done,
	output logic [63:0]                o_res
);
	import bfm_pkg::*;

	// ----------------------------------------------------------------
	// Product
	// ----------------------------------------------------------------
	// Whole product is formed at start and held; the countdown models
	// the multi-cycle latency so the core stalls as a real array would.
	logic [63:0] res_d, res_q;
	logic [7:0]  cnt_d, cnt_q;
	logic        done_d, done_q;
	logic [63:0] prod_s, prod_u;

	always_comb
	begin
		prod_s = 64'($signed({{32{i_a[31]}}, i_a}) * $signed({{32{i_b[31]}}, i_b}));
		prod_u = 64'({32'h0, i_a} * {32'h0, i_b});
		res_d  = res_q;
		cnt_d  = cnt_q;
		done_d = 1'b0;
		if (i_start)
		begin
			cnt_d = 8'(CYCLES);
			case (i_mode)
				BFM_MUL_SACC:  res_d = prod_s + {i_hi, i_lo};
				BFM_MUL_UADD2: res_d = prod_u + {32'h0, i_lo} + {32'h0, i_hi};
				default:       res_d = prod_s;
			endcase
		end
		else if (cnt_q != 8'h00)
		begin
			cnt_d  = cnt_q - 8'h01;
			done_d = (cnt_q == 8'h01);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			res_q  <= 64'h0;
			cnt_q  <= 8'h00;
			done_q <= 1'b0;
		end
		else
		begin
			res_q  <= res_d;
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign o_done = done_q;
	assign o_res  = res_q;

endmodule

// ---- rtl/bfm_datapath.sv ----
`timescale 1ns/1ps
module bfm_datapath #(
	parameter int unsigned MUL_LAT = bfm_pkg::MUL_CYCLES
) (
	// Clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_rstn,
	// Operation request from decode
	input  wire logic               i_valid,
	input  wire bfm_pkg::bfm_op_t   i_op,
	input  wire logic               i_setflags,
	input  wire logic [3:0]         i_flags,
	input  wire logic [31:0]        i_src_a,
	input  wire logic [31:0]        i_src_b,
	input  wire logic [31:0]        i_acc_lo,
	input  wire logic [31:0]        i_acc_hi,
	input  wire logic [4:0]         i_lsb,
	input  wire logic [4:0]         i_width_m1,
	input  wire logic [1:0]         i_rot,
	// Multiple and paired transfers
	input  wire logic [15:0]        i_reglist,
	input  wire logic [31:0]        i_base,
	input  wire logic [31:0]        i_sp,
	input  wire logic [31:0]        i_offset,
	input  wire logic               i_writeback,
	input  wire logic               i_excl_ok,
	input  wire logic [31:0]        i_rd_data,
	// Memory answer
	input  wire logic               i_mem_ready,
	input  wire logic [31:0]        i_mem_rdata,
	// Results to register file
	output logic                    o_busy,
	output logic                    o_done,
	output logic [31:0]             o_res_lo,
	output logic [31:0]             o_res_hi,
	output logic                    o_res_we,
	output logic                    o_res_hi_we,
	output logic [3:0]              o_flags,
	output logic                    o_flags_we,
	output logic                    o_base_we,
	output logic [31:0]             o_base_wdata,
	output logic [3:0]              o_rd_idx,
	output logic                    o_rf_we,
	output logic [3:0]              o_rf_idx,
	output logic [31:0]             o_rf_wdata,
	// Memory request
	output logic                    o_mem_req,
	output logic                    o_mem_we,
	output logic [31:0]             o_mem_addr,
	output logic [31:0]             o_mem_wdata,
	output bfm_pkg::bfm_size_t      o_mem_size
);
	import bfm_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] ror8(input logic [31:0] x, input logic [1:0] r);
		case (r)
			2'h1:    ror8 = {x[7:0], x[31:8]};
			2'h2:    ror8 = {x[15:0], x[31:16]};
			2'h3:    ror8 = {x[23:0], x[31:24]};
			default: ror8 = x;
		endcase
	endfunction

	function automatic logic [4:0] count16(input logic [15:0] m);
		count16 = 5'h00;
		for (int i = 0; i < 16; i++)
			count16 = count16 + {4'h0, m[i]};
	endfunction

	function automatic logic [3:0] first16(input logic [15:0] m);
		first16 = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (m[i])
				first16 = 4'(i);
	endfunction

	function automatic logic [31:0] field(input logic [31:0] x, input logic [4:0] lsb,
		input logic [4:0] wm1, input logic sgn);
		logic [31:0] sh;
		logic [31:0] m;
		sh = x >> lsb;
		m  = (wm1 == 5'h1F) ? 32'hFFFF_FFFF : ((32'h1 << ({1'b0, wm1} + 6'h01)) - 32'h1);
		field = (sgn && sh[wm1]) ? (sh | ~m) : (sh & m);
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MUL  = 3'b010,
		ST_XFER = 3'b100
	} bfm_state_t;

	bfm_state_t  state_d, state_q;
	bfm_op_t     op_d, op_q;
	logic [31:0] a_d, a_q, b_d, b_q, addr_d, addr_q, wbv_d, wbv_q;
	logic [15:0] mask_d, mask_q;
	logic        wb_d, wb_q;
	logic        busy_d, done_d, res_we_d, hi_we_d, fl_we_d, base_we_d, rf_we_d;
	logic        req_d, we_d;
	logic [31:0] lo_d, hi_d, basew_d, rfw_d, maddr_d, mwd_d;
	logic [3:0]  fl_d, idx_d, rfi_d;
	bfm_size_t   size_d;
	logic        mul_start, mul_done;
	logic [63:0] mul_res;
	bfm_mul_mode_t mul_mode;

	// The multiply ops get their own multiplier; single-cycle ops bypass it but are not accepted until a running multiply is done
	bfm_mul #(
		.CYCLES (MUL_LAT)
	) u_mul (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_start   (mul_start),
		.i_mode    (mul_mode),
		.i_a       (i_src_a),
		.i_b       (i_src_b),
		.i_lo      (i_acc_lo),
		.i_hi      (i_acc_hi),
		.o_done    (mul_done),
		.o_res     (mul_res)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [31:0] r;
		logic [31:0] sbase;
		logic [31:0] span;
		logic [15:0] mnx;
		logic [31:0] rt;
		r = 32'h0; sbase = 32'h0; span = 32'h0; mnx = 16'h0;
		// Rotated operand for the widen ops, formed once
		rt = ror8(i_src_a, i_rot);
		state_d = state_q; op_d = op_q; a_d = a_q; b_d = b_q;
		addr_d = addr_q; wbv_d = wbv_q; mask_d = mask_q; wb_d = wb_q;
		lo_d = o_res_lo; hi_d = o_res_hi; fl_d = o_flags; basew_d = o_base_wdata;
		idx_d = o_rd_idx; rfi_d = o_rf_idx; rfw_d = o_rf_wdata;
		req_d = o_mem_req; we_d = o_mem_we; maddr_d = o_mem_addr;
		mwd_d = o_mem_wdata; size_d = o_mem_size;
		done_d = 1'b0; res_we_d = 1'b0; hi_we_d = 1'b0; fl_we_d = 1'b0;
		base_we_d = 1'b0; rf_we_d = 1'b0; mul_start = 1'b0;
		mul_mode = (i_op == BFM_OP_SMUL_ACC) ? BFM_MUL_SACC :
			(i_op == BFM_OP_UMUL_ADD2) ? BFM_MUL_UADD2 : BFM_MUL_PLAIN;
		case (state_q)
			ST_IDLE:
			begin
				if (i_valid)
				begin
					op_d = i_op;
					a_d  = i_src_a;
					b_d  = i_src_b;
					case (i_op)
						BFM_OP_SMUL_ACC, BFM_OP_SMUL_LONG, BFM_OP_UMUL_ADD2:
						begin
							mul_start = 1'b1;
							state_d   = ST_MUL;
						end
						BFM_OP_POP, BFM_OP_PUSH, BFM_OP_STORE_ASC, BFM_OP_STORE_DESC:
						begin
							sbase  = (i_op == BFM_OP_POP || i_op == BFM_OP_PUSH) ? i_sp : i_base;
							span   = {25'h0, count16(i_reglist), 2'h0};
							mask_d = i_reglist;
							idx_d  = first16(i_reglist);
							wb_d   = i_writeback || i_op == BFM_OP_POP || i_op == BFM_OP_PUSH;
							// Descending forms start at the lowest word: lowest register lowest
							if (i_op == BFM_OP_PUSH || i_op == BFM_OP_STORE_DESC)
							begin
								addr_d = sbase - span;
								wbv_d  = sbase - span;
							end
							else
							begin
								addr_d = sbase;
								wbv_d  = sbase + span;
							end
							if (i_reglist == 16'h0)
								done_d = 1'b1;
							else
								state_d = ST_XFER;
						end
						BFM_OP_STORE_PAIR:
						begin
							mask_d  = PAIR_MASK;
							idx_d   = 4'h0;
							wb_d    = 1'b0;
							addr_d  = i_base + i_offset;
							state_d = ST_XFER;
						end
						BFM_OP_EXCL_BYTE, BFM_OP_EXCL_HALF:
						begin
							mask_d = EXCL_MASK;
							idx_d  = 4'h0;
							wb_d   = 1'b0;
							addr_d = i_base;
							if (i_excl_ok)
								state_d = ST_XFER;
							else
							begin
								lo_d     = EXCL_FAILED;
								res_we_d = 1'b1;
								done_d   = 1'b1;
							end
						end
						default:
						begin
							case (i_op)
								BFM_OP_BSW_WORD:
									r = {i_src_a[7:0], i_src_a[15:8], i_src_a[23:16], i_src_a[31:24]};
								BFM_OP_BSW_HALVES:
									r = {i_src_a[23:16], i_src_a[31:24], i_src_a[7:0], i_src_a[15:8]};
								BFM_OP_BSW_LOW_SX:
									r = {{16{i_src_a[7]}}, i_src_a[7:0], i_src_a[15:8]};
								BFM_OP_ROT_CARRY:
									r = {i_flags[FLAG_C], i_src_a[31:1]};
								BFM_OP_SFX:
									r = field(i_src_a, i_lsb, i_width_m1, 1'b1);
								BFM_OP_UFX:
									r = field(i_src_a, i_lsb, i_width_m1, 1'b0);
								BFM_OP_SWH:
									r = {{16{rt[15]}}, rt[15:0]};
								BFM_OP_ZWH:
									r = {16'h0, rt[15:0]};
								default:
									r = RST_WORD;
							endcase
							lo_d     = r;
							res_we_d = 1'b1;
							done_d   = 1'b1;
							// Flags move only for the flag-setting rotate
							if (i_op == BFM_OP_ROT_CARRY && i_setflags)
							begin
								fl_d         = i_flags;
								fl_d[FLAG_N] = r[31];
								fl_d[FLAG_Z] = (r == 32'h0);
								fl_d[FLAG_C] = i_src_a[0];
								fl_we_d      = 1'b1;
							end
						end
					endcase
				end
			end
			ST_MUL:
			begin
				if (mul_done)
				begin
					lo_d     = mul_res[31:0];
					hi_d     = mul_res[63:32];
					res_we_d = 1'b1;
					hi_we_d  = 1'b1;
					done_d   = 1'b1;
					state_d  = ST_IDLE;
				end
			end
			ST_XFER:
			begin
				if (!o_mem_req)
				begin
					req_d   = 1'b1;
					we_d    = (op_q != BFM_OP_POP);
					maddr_d = addr_q;
					size_d  = (op_q == BFM_OP_EXCL_BYTE) ? BFM_SIZE_BYTE :
						(op_q == BFM_OP_EXCL_HALF) ? BFM_SIZE_HALF : BFM_SIZE_WORD;
					// Pair and exclusive data was captured at accept
					if (op_q == BFM_OP_STORE_PAIR || op_q == BFM_OP_EXCL_BYTE ||
						op_q == BFM_OP_EXCL_HALF)
						mwd_d = (o_rd_idx == 4'h0) ? a_q : b_q;
					else
						mwd_d = i_rd_data;
				end
				else if (i_mem_ready)
				begin
					req_d  = 1'b0;
					addr_d = addr_q + WORD_STEP;
					if (op_q == BFM_OP_POP)
					begin
						rf_we_d = 1'b1;
						rfi_d   = o_rd_idx;
						rfw_d   = i_mem_rdata;
					end
					mnx    = mask_q & ~(16'h0001 << o_rd_idx);
					mask_d = mnx;
					idx_d  = first16(mnx);
					if (mnx == 16'h0)
					begin
						done_d    = 1'b1;
						state_d   = ST_IDLE;
						base_we_d = wb_q;
						basew_d   = wbv_q;
						if (op_q == BFM_OP_EXCL_BYTE || op_q == BFM_OP_EXCL_HALF)
						begin
							lo_d     = EXCL_DONE;
							res_we_d = 1'b1;
						end
					end
				end
			end
			default:
				state_d = ST_IDLE;
		endcase
		busy_d = (state_d != ST_IDLE);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_q <= ST_IDLE; op_q <= BFM_OP_BSW_WORD;
			a_q <= RST_WORD; b_q <= RST_WORD; addr_q <= RST_WORD; wbv_q <= RST_WORD;
			mask_q <= 16'h0; wb_q <= 1'b0;
			o_busy <= 1'b0; o_done <= 1'b0; o_res_we <= 1'b0; o_res_hi_we <= 1'b0;
			o_res_lo <= RST_WORD; o_res_hi <= RST_WORD; o_flags <= 4'h0;
			o_flags_we <= 1'b0; o_base_we <= 1'b0; o_base_wdata <= RST_WORD;
			o_rd_idx <= 4'h0; o_rf_we <= 1'b0; o_rf_idx <= 4'h0; o_rf_wdata <= RST_WORD;
			o_mem_req <= 1'b0; o_mem_we <= 1'b0; o_mem_addr <= RST_WORD;
			o_mem_wdata <= RST_WORD; o_mem_size <= BFM_SIZE_WORD;
		end
		else
		begin
			state_q <= state_d; op_q <= op_d;
			a_q <= a_d; b_q <= b_d; addr_q <= addr_d; wbv_q <= wbv_d;
			mask_q <= mask_d; wb_q <= wb_d;
			o_busy <= busy_d; o_done <= done_d; o_res_we <= res_we_d; o_res_hi_we <= hi_we_d;
			o_res_lo <= lo_d; o_res_hi <= hi_d; o_flags <= fl_d;
			o_flags_we <= fl_we_d; o_base_we <= base_we_d; o_base_wdata <= basew_d;
			o_rd_idx <= idx_d; o_rf_we <= rf_we_d; o_rf_idx <= rfi_d; o_rf_wdata <= rfw_d;
			o_mem_req <= req_d; o_mem_we <= we_d; o_mem_addr <= maddr_d;
			o_mem_wdata <= mwd_d; o_mem_size <= size_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	localparam int MUL_WAIT_MAX = 12;

	sequence s_mul_accept;
		state_q == ST_IDLE && i_valid &&
			(i_op == BFM_OP_SMUL_ACC || i_op == BFM_OP_SMUL_LONG || i_op == BFM_OP_UMUL_ADD2);
	endsequence

	sequence s_word_step;
		!o_mem_req ##1 (o_mem_req && o_mem_addr == $past(o_mem_addr, 2) + WORD_STEP);
	endsequence

	property p_swap_word;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_done && op_q == BFM_OP_BSW_WORD |->
			o_res_lo == {a_q[7:0], a_q[15:8], a_q[23:16], a_q[31:24]} && !o_flags_we;
	endproperty
	a_swap_word: assert property (p_swap_word) else $error("word byte swap wrong");

	property p_swap_halves;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_done && op_q == BFM_OP_BSW_HALVES |->
			o_res_lo == {a_q[23:16], a_q[31:24], a_q[7:0], a_q[15:8]};
	endproperty
	a_swap_halves: assert property (p_swap_halves) else $error("halves swap wrong");

	property p_swap_low_sx;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_done && op_q == BFM_OP_BSW_LOW_SX |->
			o_res_lo == {{16{a_q[7]}}, a_q[7:0], a_q[15:8]};
	endproperty
	a_swap_low_sx: assert property (p_swap_low_sx) else $error("low signed swap wrong");

	property p_rot_carry;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_flags_we |-> o_res_lo[30:0] == a_q[31:1] && o_flags[FLAG_C] == a_q[0] &&
			o_flags[FLAG_Z] == (o_res_lo == 32'h0) && o_flags[FLAG_N] == o_res_lo[31];
	endproperty
	a_rot_carry: assert property (p_rot_carry) else $error("rotate flags wrong");

	property p_flags_only_rot;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_flags_we |-> op_q == BFM_OP_ROT_CARRY && o_done && $past(i_setflags);
	endproperty
	a_flags_only_rot: assert property (p_flags_only_rot) else $error("stray flag write");

	property p_mul_bounded;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_mul_accept |=> (o_busy || o_done) throughout (##[1:MUL_WAIT_MAX] (o_done && o_res_hi_we));
	endproperty
	a_mul_bounded: assert property (p_mul_bounded) else $error("multiply never done");

	property p_smul_long;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_done && op_q == BFM_OP_SMUL_LONG |->
			{o_res_hi, o_res_lo} == 64'($signed({{32{a_q[31]}}, a_q}) * $signed({{32{b_q[31]}}, b_q}));
	endproperty
	a_smul_long: assert property (p_smul_long) else $error("signed product wrong");

	property p_list_ascend;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_mem_req && i_mem_ready && $countones(mask_q) > 1 |=> s_word_step;
	endproperty
	a_list_ascend: assert property (p_list_ascend) else $error("next word address wrong");

	property p_push_writes;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_mem_req && op_q == BFM_OP_PUSH |-> o_mem_we && o_mem_size == BFM_SIZE_WORD;
	endproperty
	a_push_writes: assert property (p_push_writes) else $error("push not a word write");

	property p_pop_load;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_rf_we |-> op_q == BFM_OP_POP && $past(i_mem_ready) && o_rf_wdata == $past(i_mem_rdata);
	endproperty
	a_pop_load: assert property (p_pop_load) else $error("pop load wrong");

	property p_excl_fail;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		state_q == ST_IDLE && i_valid && !i_excl_ok &&
			(i_op == BFM_OP_EXCL_BYTE || i_op == BFM_OP_EXCL_HALF) |=>
			o_done && o_res_we && o_res_lo == EXCL_FAILED && !o_mem_req;
	endproperty
	a_excl_fail: assert property (p_excl_fail) else $error("failed exclusive wrong");

endmodule

// ---- sim/bfm_mem_model.sv ----
`timescale 1ns/1ps
module bfm_mem_model (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// Request from the datapath
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_rd_idx,
	input  wire logic [3:0]  i_slow,
	// Answers
	output logic             o_ready,
	output logic [31:0]      o_rdata,
	output logic [31:0]      o_rd_data
);
	logic [3:0]  cnt_q;
	logic [31:0] log_addr[$];
	logic [31:0] log_data[$];
	assign o_ready = i_req && (cnt_q == i_slow);
	// Off-ready data moves each wait cycle; on odd counts it equals the load value ~i_addr
	assign o_rdata = o_ready ? ~i_addr : {32{cnt_q[0]}} ^ i_addr;
	assign o_rd_data = {20'h10000, {3{i_rd_idx}}};
	always @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn || !i_req || o_ready)
			cnt_q <= 4'h0;
		else
			cnt_q <= cnt_q + 4'h1;
		if (i_rstn && o_ready)
		begin
			log_addr.push_back(i_addr);
			log_data.push_back(i_wdata);
		end
	end
endmodule

// ---- sim/tb_byte_bitfield_multiply_datapath.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_byte_bitfield_multiply_datapath;
	import bfm_pkg::*;
	logic        i_clk_sys, i_rstn, i_valid, i_setflags, i_writeback, i_excl_ok, i_mem_ready;
	bfm_op_t     i_op;
	logic [3:0]  i_flags, i_slow, o_flags, o_rd_idx, o_rf_idx;
	logic [31:0] i_src_a, i_src_b, i_acc_lo, i_acc_hi, i_base, i_sp, i_offset;
	logic [31:0] i_rd_data, i_mem_rdata, o_res_lo, o_res_hi, o_base_wdata, o_rf_wdata;
	logic [31:0] o_mem_addr, o_mem_wdata, a, b, r, st;
	logic [4:0]  i_lsb, i_width_m1;
	logic [1:0]  i_rot;
	logic [15:0] i_reglist;
	logic        o_busy, o_done, o_res_we, o_res_hi_we, o_flags_we, o_base_we, o_rf_we;
	logic        o_mem_req, o_mem_we;
	bfm_size_t   o_mem_size;
	logic [63:0] p;
	int          error_cnt, checked, seed, k, j, n, i;
	logic [2:0]  mq[$];
	logic [35:0] rq[$];
	bfm_datapath #(.MUL_LAT(MUL_CYCLES)) dut (.*);
	bfm_mem_model mem (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_req(o_mem_req),
		.i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_rd_idx(o_rd_idx),
		.i_slow(i_slow), .o_ready(i_mem_ready), .o_rdata(i_mem_rdata), .o_rd_data(i_rd_data));
	// Sampling 0.5 ns after each rising edge sees each accepted word and each load pulse exactly once
	always @(posedge i_clk_sys)
	begin
		#0.5;
		if (o_mem_req && i_mem_ready) mq.push_back({o_mem_we, o_mem_size});
		if (o_rf_we) rq.push_back({o_rf_idx, o_rf_wdata});
	end
	initial
	begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	// ----------------------------------------------------------------
	// Reference and drivers
	// ----------------------------------------------------------------
	function automatic logic [31:0] ref1(bfm_op_t op, logic [31:0] x);
		logic [31:0] y;
		logic [31:0] z;
		y = (x >> (8 * i_rot)) | (x << (32 - 8 * i_rot));
		z = (x >> i_lsb) << (31 - i_width_m1);
		case (op)
			BFM_OP_BSW_WORD: return {x[7:0], x[15:8], x[23:16], x[31:24]};
			BFM_OP_BSW_HALVES: return {x[23:16], x[31:24], x[7:0], x[15:8]};
			BFM_OP_BSW_LOW_SX: return {{16{x[7]}}, x[7:0], x[15:8]};
			BFM_OP_ROT_CARRY: return {i_flags[FLAG_C], x[31:1]};
			BFM_OP_SFX: return $signed(z) >>> (31 - i_width_m1);
			BFM_OP_UFX: return z >> (31 - i_width_m1);
			BFM_OP_SWH: return {{16{y[15]}}, y[15:0]};
			default: return {16'h0000, y[15:0]};
		endcase
	endfunction
	// Lets an edge pass so valid never drops and rises in one step; returns in the done cycle
	task automatic run(input bfm_op_t op);
		int w;
		w = 0;
		@(posedge i_clk_sys) #1;
		mem.log_addr.delete();
		mem.log_data.delete();
		mq.delete();
		rq.delete();
		i_op = op;
		i_valid = 1'b1;
		@(posedge i_clk_sys) #1;
		i_valid = 1'b0;
		while (o_done !== 1'b1 && w < 300)
		begin
			@(posedge i_clk_sys) #1;
			w++;
		end
		if (w == 300) error_cnt++;
	endtask
	task automatic complete_run;
		if (error_cnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#100000;
		error_cnt++;
		complete_run;
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		{i_valid, i_setflags, i_writeback, i_excl_ok, i_flags, i_lsb, i_width_m1, i_rot} = '0;
		{i_src_a, i_src_b, i_acc_lo, i_acc_hi, i_base, i_sp, i_offset, i_reglist, i_slow} = '0;
		i_op = BFM_OP_BSW_WORD;
		seed = 32'h165B64EB;
		i_rstn = 1'b0;
		repeat (6) @(posedge i_clk_sys);
		#1 i_rstn = 1'b1;
		`CHK("idle", 1'b0, o_busy | o_done | o_mem_req)
		for (k = 0; k < 160; k++)
		begin
			a = $random(seed);
			i_src_a = a;
			i_src_b = a;
			i_flags = 4'($random(seed));
			i_setflags = 1'($random(seed));
			i_rot = 2'($random(seed));
			i_lsb = 5'($random(seed));
			i_width_m1 = 5'($unsigned($random(seed)) % (32 - i_lsb));
			run(bfm_op_t'(k % 8));
			r = ref1(i_op, a);
			`CHK("res", r, o_res_lo)
			`CHK("flags_we", i_op == BFM_OP_ROT_CARRY && i_setflags, o_flags_we)
			if (o_flags_we) `CHK("flags", {r[31], r == 0, a[0], i_flags[0]}, o_flags)
		end
		for (k = 0; k < 12; k++)
		begin
			a = $random(seed);
			b = $random(seed);
			i_src_a = a;
			i_src_b = b;
			i_acc_lo = $random(seed);
			i_acc_hi = $random(seed);
			run(bfm_op_t'(5'h08 + k % 3));
			if (i_op == BFM_OP_UMUL_ADD2) p = {32'h0, a} * {32'h0, b} + i_acc_lo + i_acc_hi;
			else p = {{32{a[31]}}, a} * {{32{b[31]}}, b}
				+ (i_op == BFM_OP_SMUL_ACC ? {i_acc_hi, i_acc_lo} : 64'h0);
			`CHK("mul", p, {o_res_hi, o_res_lo})
			`CHK("mul_we", 3'b110, {o_res_we, o_res_hi_we, o_flags_we})
		end
		for (k = 0; k < 20; k++)
		begin
			i_reglist = (k == 5) ? 16'h0000 : 16'($random(seed));
			i_base = 32'h2000_0000 | ($random(seed) & 32'h0000_FFFC);
			i_sp = i_base;
			i_writeback = 1'($random(seed));
			i_slow = 4'($unsigned($random(seed)) % 4);
			run(bfm_op_t'(5'h0B + k % 4));
			n = $countones(i_reglist);
			st = (i_op == BFM_OP_PUSH || i_op == BFM_OP_STORE_DESC) ? i_base - 4 * n : i_base;
			j = 0;
			for (i = 0; i < 16; i++)
				if (i_reglist[i])
				begin
					`CHK("addr", st + 4 * j, mem.log_addr[j])
					if (i_op != BFM_OP_POP) `CHK("data", {20'h10000, {3{i[3:0]}}}, mem.log_data[j])
					`CHK("wsz", {i_op != BFM_OP_POP, BFM_SIZE_WORD}, mq[j])
					if (i_op == BFM_OP_POP) `CHK("pop_rf", {i[3:0], ~(st + 4 * j)}, rq[j])
					j++;
				end
			`CHK("rf_cnt", i_op == BFM_OP_POP ? n : 0, rq.size())
			`CHK("count", n, mem.log_addr.size())
			`CHK("wb", (i_op inside {BFM_OP_POP, BFM_OP_PUSH} || i_writeback) && n != 0, o_base_we)
			if (o_base_we) `CHK("wbval", i_op inside {BFM_OP_POP, BFM_OP_STORE_ASC} ? i_base + 4 * n : st, o_base_wdata)
		end
		i_base = 32'h2000_1000;
		i_offset = 32'h0000_0018;
		i_src_a = $random(seed);
		i_src_b = $random(seed);
		run(BFM_OP_STORE_PAIR);
		for (j = 0; j < 2; j++)
		begin
			`CHK("pair_addr", i_base + i_offset + 4 * j, mem.log_addr[j])
			`CHK("pair_data", j ? i_src_b : i_src_a, mem.log_data[j])
		end
		for (k = 0; k < 4; k++)
		begin
			i_excl_ok = k[1];
			run(bfm_op_t'(5'h10 + k % 2));
			`CHK("status", i_excl_ok ? EXCL_DONE : EXCL_FAILED, o_res_lo)
			`CHK("xwr", int'(i_excl_ok), mem.log_addr.size())
			if (i_excl_ok) `CHK("xsize", {1'b1, k[0] ? BFM_SIZE_HALF : BFM_SIZE_BYTE}, mq[0])
			if (i_excl_ok) `CHK("xdata", i_src_a, mem.log_data[0])
		end
		complete_run;
	end
endmodule
